/* rtl/cts_consts.svh */
// Register offsets, bit positions, reset values and timing figures of the bus supervisor
`ifndef CTS_CONSTS_SVH
`define CTS_CONSTS_SVH
`define CTS_OFF_MODE    8'h00
`define CTS_OFF_DIAG    8'h04
`define CTS_OFF_INH     8'h08
`define CTS_OFF_WAKE    8'h0C
`define CTS_OFF_STAT    8'h10
`define CTS_MODE_SLEEP  2'h0
`define CTS_MODE_LISTEN 2'h1
`define CTS_MODE_WSLEEP 2'h2
`define CTS_MODE_NORMAL 2'h3
`define CTS_MODE_RST    2'h3
`define CTS_TOSEL_BIT   2
`define CTS_F_HBATT     0
`define CTS_F_HGND      1
`define CTS_F_LBATT     2
`define CTS_F_LGND      3
`define CTS_F_DOM       4
`define CTS_F_RXREC     5
`define CTS_F_TXLOW     6
`define CTS_F_OT        7
`define CTS_F_OC        8
`define CTS_NFLAG       9
`define CTS_ERR_MASK    9'h0F0
`define CTS_I_TXD       0
`define CTS_I_BUS       1
`define CTS_I_RXMON     2
`define CTS_I_LLOW      3
`define CTS_I_HHIGH     4
`define CTS_I_LOC       5
`define CTS_I_HOC       6
`define CTS_I_HOT       7
`define CTS_I_COOL      8
`define CTS_NIN         9
`define CTS_SYNC_RST    9'h105
`define CTS_CLK_NS      10
`define CTS_SAMPLE_NS   500
`define CTS_SHORT_HITS  5
`define CTS_RXREC_HITS  7
`define CTS_TXDOM_NS    2000000
`define CTS_BUSDOM_NS   2000000
`define CTS_PWU1_NS     5000
`define CTS_PWU3_NS     2000
`define CTS_WTO1_NS     1000000
`define CTS_WTO2_NS     2000000
`endif

/* rtl/cts_pkg.sv */
// Types and cycle arithmetic shared by the bus supervisor files
`include "cts_consts.svh"
package cts_pkg;
	typedef logic [23:0] cts_cnt_t;                  // Timer width
	typedef enum logic [1:0] {WK_IDLE, WK_FIRST, WK_SECOND, WK_THIRD} cts_wake_e;
	typedef struct packed {
		logic [1:0]            mode;                  // Transceiver mode field
		logic [1:0]            saved_mode;            // Mode held across low-power off
		logic                  to_sel;                // Wake timeout select
		logic                  inhibit;               // Bus interrupt inhibit bit
		logic [`CTS_NFLAG-1:0] flags;                 // Sticky diagnostic and error flags
		logic                  wake;                  // Bus wake recorded
		logic                  txd_lock;              // Drivers off: transmit stuck low
		logic                  rx_lock;               // Drivers and receiver off
		logic                  ot_lock;               // Drivers off: overtemperature
		logic                  low_power_off_state_d;               // Previous low-power state
		logic                  txd_d;                 // Previous transmit level
		logic                  bus_d;                 // Previous bus level
		logic                  saw_rx_low;            // Receive seen low this dominant period
		cts_cnt_t              txdom_cnt;             // Transmit low time
		cts_cnt_t              busdom_cnt;            // Bus dominant time
		logic [7:0]            smp_cnt;               // Delay to short sample
		cts_wake_e             wk;                    // Wake pulse sequencer
		cts_cnt_t              wk_len;                // Current pulse length
		cts_cnt_t              wk_to;                 // Remaining sequence time
	} cts_state_s;
	// Least time in cycles, rounded up, never below one
	function automatic cts_cnt_t cyc_min(input int unsigned ns);
		int unsigned c;
		c = (ns + `CTS_CLK_NS - 1) / `CTS_CLK_NS;
		if (c < 1) c = 1;
		return c[23:0];
	endfunction : cyc_min
	// Longest time in cycles, rounded down, never below one
	function automatic cts_cnt_t cyc_max(input int unsigned ns);
		int unsigned c;
		c = ns / `CTS_CLK_NS;
		if (c < 1) c = 1;
		return c[23:0];
	endfunction : cyc_max
endpackage : cts_pkg

/* rtl/cts_hit_counter.sv */
// Consecutive hit counter for sampled fault comparators
`timescale 1ns/10ps
module cts_hit_counter #(
	parameter int unsigned HITS = 5
) (
	input  wire logic hclk,       // System clock
	input  wire logic hresetn,    // Asynchronous reset, low active
	input  wire logic hclken,     // Clock enable
	input  wire logic sample,     // One-cycle sample strobe
	input  wire logic hit,        // Comparator result at the strobe
	output logic      trip        // One-cycle pulse after HITS hits in a row
);
	localparam int unsigned CW = $clog2(HITS + 1);
	logic [CW-1:0] cnt_r;         // Hits in a row so far
	logic [CW-1:0] cnt_nxt;
	logic          trip_nxt;
	// A miss restarts the run so that only an unbroken run trips
	always_comb begin
		cnt_nxt  = cnt_r;
		trip_nxt = 1'b0;
		if (sample) begin
			if (!hit) begin
				cnt_nxt = '0;
			end else if (cnt_r == CW'(HITS - 1)) begin
				cnt_nxt  = '0;
				trip_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
	end
	// State registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= '0;
			trip  <= 1'b0;
		end else if (hclken) begin
			cnt_r <= cnt_nxt;
			trip  <= trip_nxt;
		end
	end
	chk_hit_trip_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(trip) && hclken |-> $past(sample) && $past(hit))
		else $error("hit counter tripped without a hit sample");
endmodule : cts_hit_counter

/* rtl/cts_supervisor.sv */
// Bus transceiver fault, mode and wake supervisor with an AHB-Lite register slave
`timescale 1ns/10ps
`include "cts_consts.svh"
module cts_supervisor #(
	parameter int unsigned TXDOM_NS  = `CTS_TXDOM_NS,   // Transmit dominant timeout
	parameter int unsigned BUSDOM_NS = `CTS_BUSDOM_NS,  // Bus dominant timeout
	parameter int unsigned PWU1_NS   = `CTS_PWU1_NS,    // First wake pulse minimum
	parameter int unsigned PWU3_NS   = `CTS_PWU3_NS,    // Follow-on wake pulse minimum
	parameter int unsigned WTO1_NS   = `CTS_WTO1_NS,    // Wake sequence timeout, choice 0
	parameter int unsigned WTO2_NS   = `CTS_WTO2_NS     // Wake sequence timeout, choice 1
) (
	input  wire logic        hclk,          // System clock, 100 MHz
	input  wire logic        hresetn,       // Asynchronous reset, low active
	input  wire logic        hclken,        // Clock enable, freezes all state when low
	input  wire logic        hsel,          // AHB-Lite slave select
	input  wire logic [7:0]  haddr,         // Byte address
	input  wire logic [1:0]  htrans,        // Transfer type
	input  wire logic        hwrite,        // Write when high
	input  wire logic [2:0]  hsize,         // Transfer size, words only
	input  wire logic [31:0] hwdata,        // Write data
	input  wire logic        hready,        // Bus ready
	output logic             hreadyout,     // Slave ready
	output logic [31:0]      hrdata,        // Read data
	output logic             hresp,         // Always OKAY
	input  wire logic        txd,           // Transmit pin from the protocol controller
	input  wire logic        rxd_mon,       // Sensed level of the receive pin
	input  wire logic        bus_dominant,  // Bus comparator, high when dominant
	input  wire logic        low_line_low,  // Low line below 0.5 V
	input  wire logic        high_line_high, // High line above 5.2 V
	input  wire logic        low_line_oc,   // Low line current above 75 mA
	input  wire logic        high_line_oc,  // High line current above 75 mA
	input  wire logic        temp_hot,      // Driver above thermal shutdown threshold
	input  wire logic        temp_cool,     // Driver below threshold minus hysteresis
	input  wire logic        low_power_off_state,         // Low-power off state, same clock domain
	output logic             rxd,           // Receive pin drive
	output logic             drv_en,        // Bus drivers enabled
	output logic             rx_en,         // Receiver enabled
	output logic             bus_drive,     // Drive the bus dominant
	output logic             err_irq        // Bus error interrupt request
);
	localparam cts_pkg::cts_cnt_t TXDOM_CYC  = cts_pkg::cyc_min(TXDOM_NS);
	localparam cts_pkg::cts_cnt_t BUSDOM_CYC = cts_pkg::cyc_min(BUSDOM_NS);
	localparam cts_pkg::cts_cnt_t PWU1_CYC   = cts_pkg::cyc_min(PWU1_NS);
	localparam cts_pkg::cts_cnt_t PWU3_CYC   = cts_pkg::cyc_min(PWU3_NS);
	localparam cts_pkg::cts_cnt_t WTO1_CYC   = cts_pkg::cyc_max(WTO1_NS);
	localparam cts_pkg::cts_cnt_t WTO2_CYC   = cts_pkg::cyc_max(WTO2_NS);
	localparam cts_pkg::cts_cnt_t SMP_FULL   = cts_pkg::cyc_min(`CTS_SAMPLE_NS);
	localparam logic [7:0]        SMP_CYC    = SMP_FULL[7:0];

	// Pin synchronisers; the first stage feeds only the second
	logic [`CTS_NIN-1:0] s1_r;          // First stage
	logic [`CTS_NIN-1:0] s2_r;          // Second stage
	logic [`CTS_NIN-1:0] s3_r;          // Third stage
	logic [`CTS_NIN-1:0] filt_r;        // Accepted levels
	logic [`CTS_NIN-1:0] filt_nxt;
	logic [`CTS_NIN-1:0] pins;          // Raw pin vector
	// State and outputs
	cts_pkg::cts_state_s st_r;          // Control state
	cts_pkg::cts_state_s n;             // Next control state
	logic                wr_q_r;        // Write data phase pending
	logic                wr_q_nxt;
	logic [7:0]          addr_q_r;      // Address of pending write
	logic [7:0]          addr_q_nxt;
	logic [31:0]         hrdata_nxt;
	logic                rxd_nxt;
	logic                drv_nxt;
	logic                rxen_nxt;
	logic                drive_nxt;
	logic                irq_nxt;
	// Decoded events
	logic                txd_f;         // Filtered transmit level
	logic                bus_f;         // Filtered bus dominant
	logic                txd_fall;      // Transmit high to low
	logic                dom_end;       // Bus dominant to recessive
	logic                dom_start;     // Bus recessive to dominant
	logic                supv;          // Fault watch active
	logic                smp_fire;      // Short sample strobe
	logic                rx_sample;     // End of a watched dominant period
	logic [3:0]          short_hit;     // Short comparators at the strobe
	logic [3:0]          short_trip;    // Five in a row per comparator
	logic                rx_trip;       // Seven dominant periods in a row with receive never low
	logic [`CTS_NFLAG-1:0] set_f;       // Flags raised this cycle
	logic [`CTS_NFLAG-1:0] clr_f;       // Flags cleared by software
	logic                clr_wake;      // Wake flag cleared by software
	logic                addr_ok;       // Valid address phase
	logic                wr_mode;       // Mode register written this cycle
	cts_pkg::cts_cnt_t   pulse_min;     // Pulse minimum for current stage

	assign pins = {temp_cool, temp_hot, high_line_oc, low_line_oc, high_line_high,
		low_line_low, rxd_mon, bus_dominant, txd};
	// A level is taken only once second and third stage agree
	assign filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
	assign txd_f    = filt_r[`CTS_I_TXD];
	assign bus_f    = filt_r[`CTS_I_BUS];
	assign short_hit = {filt_r[`CTS_I_HOC], filt_r[`CTS_I_LOC],
		filt_r[`CTS_I_HHIGH], filt_r[`CTS_I_LLOW]};

	// Synchroniser registers; each stage starts at its pin's idle level so that
	// release of reset shows neither a false edge nor a false hot or short level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r   <= `CTS_SYNC_RST;
			s2_r   <= `CTS_SYNC_RST;
			s3_r   <= `CTS_SYNC_RST;
			filt_r <= `CTS_SYNC_RST;
		end else if (hclken) begin
			s1_r   <= pins;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			filt_r <= filt_nxt;
		end
	end

	// Short counters, one per comparator, then the receive check
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_short
			cts_hit_counter #(.HITS(`CTS_SHORT_HITS)) u_short (
				.hclk    (hclk),
				.hresetn (hresetn),
				.hclken  (hclken),
				.sample  (smp_fire),
				.hit     (short_hit[gi]),
				.trip    (short_trip[gi])
			);
		end
	endgenerate
	cts_hit_counter #(.HITS(`CTS_RXREC_HITS)) u_rxrec (
		.hclk    (hclk),
		.hresetn (hresetn),
		.hclken  (hclken),
		.sample  (rx_sample),
		.hit     (!st_r.saw_rx_low),
		.trip    (rx_trip)
	);

	// Edge and window decode
	always_comb begin
		txd_fall  = st_r.txd_d & ~txd_f;
		dom_end   = st_r.bus_d & ~bus_f;
		dom_start = ~st_r.bus_d & bus_f;
		supv      = ~low_power_off_state & st_r.mode[0];
		smp_fire  = (st_r.smp_cnt == 8'h01) & ~txd_f;
		rx_sample = supv & rx_en & dom_end;
		addr_ok   = hsel & htrans[1] & hready;
		wr_mode   = wr_q_r & (addr_q_r == `CTS_OFF_MODE) & ~low_power_off_state;
		pulse_min = (st_r.wk == cts_pkg::WK_FIRST) ? PWU1_CYC : PWU3_CYC;
	end

	// Next control state, register access and outputs
	always_comb begin
		n          = st_r;
		set_f      = '0;
		clr_f      = '0;
		clr_wake   = 1'b0;
		wr_q_nxt   = addr_ok & hwrite;
		addr_q_nxt = addr_ok ? haddr : addr_q_r;
		hrdata_nxt = 32'h00000000;
		n.txd_d    = txd_f;
		n.bus_d    = bus_f;
		n.low_power_off_state_d  = low_power_off_state;
		// Read data is fetched in the address phase; unmapped reads give zero
		if (addr_ok && !hwrite) begin
			case (haddr)
				`CTS_OFF_MODE: hrdata_nxt = {29'h0, st_r.to_sel, st_r.mode};
				`CTS_OFF_DIAG: hrdata_nxt = {23'h0, st_r.flags};
				`CTS_OFF_INH:  hrdata_nxt = {31'h0, st_r.inhibit};
				`CTS_OFF_WAKE: hrdata_nxt = {31'h0, st_r.wake};
				`CTS_OFF_STAT: hrdata_nxt = {26'h0, low_power_off_state, rx_en, drv_en,
					st_r.ot_lock, st_r.rx_lock, st_r.txd_lock};
				default:       hrdata_nxt = 32'h00000000;
			endcase
		end
		// Writes land in the data phase; unmapped writes are dropped
		if (wr_q_r) begin
			case (addr_q_r)
				`CTS_OFF_DIAG: clr_f = hwdata[`CTS_NFLAG-1:0];
				`CTS_OFF_INH:  n.inhibit = hwdata[0];
				`CTS_OFF_WAKE: clr_wake = hwdata[0];
				default:       ;
			endcase
		end
		// Mode writes are held off in low-power off, where the mode is managed here
		if (wr_mode) begin
			n.mode   = hwdata[1:0];
			n.to_sel = hwdata[`CTS_TOSEL_BIT];
			if (hwdata[1:0] == `CTS_MODE_NORMAL) n.rx_lock = 1'b0;
		end
		// Transmit lock lifts only in normal mode with transmit back high
		if (st_r.mode == `CTS_MODE_NORMAL && txd_f) n.txd_lock = 1'b0;
		// Thermal lock needs normal mode, cooling and a fresh transmit fall
		if (st_r.mode == `CTS_MODE_NORMAL && filt_r[`CTS_I_COOL] && txd_fall) begin
			n.ot_lock = 1'b0;
		end
		// Transmit low time
		n.txdom_cnt = (supv && !txd_f && st_r.txdom_cnt != TXDOM_CYC) ?
			st_r.txdom_cnt + 1'b1 : (supv && !txd_f ? st_r.txdom_cnt : '0);
		if (supv && !txd_f && st_r.txdom_cnt == TXDOM_CYC - 1'b1) begin
			set_f[`CTS_F_TXLOW] = 1'b1;
			n.txd_lock = 1'b1;
		end
		// Bus dominant time; flag only, the driver stays as it is
		n.busdom_cnt = (supv && bus_f && st_r.busdom_cnt != BUSDOM_CYC) ?
			st_r.busdom_cnt + 1'b1 : (supv && bus_f ? st_r.busdom_cnt : '0);
		if (supv && bus_f && st_r.busdom_cnt == BUSDOM_CYC - 1'b1) begin
			set_f[`CTS_F_DOM] = 1'b1;
		end
		// Receive pin seen low at any point of a dominant period
		if (dom_start) n.saw_rx_low = 1'b0;
		else if (bus_f && !filt_r[`CTS_I_RXMON]) n.saw_rx_low = 1'b1;
		if (rx_trip) begin
			set_f[`CTS_F_RXREC] = 1'b1;
			n.rx_lock = 1'b1;
		end
		// Thermal shutdown; a hot level while locked does not re-arm
		if (filt_r[`CTS_I_HOT] && !st_r.ot_lock && !low_power_off_state) begin
			set_f[`CTS_F_OT] = 1'b1;
			n.ot_lock = 1'b1;
		end
		// Every error shutdown drops the mode to listen or sleep
		if (set_f[`CTS_F_TXLOW] || set_f[`CTS_F_RXREC] || set_f[`CTS_F_OT]) begin
			n.mode[1] = 1'b0;
		end
		// Short sampling: 500 ns after each transmit fall while driving
		if (txd_fall && drv_en) n.smp_cnt = SMP_CYC;
		else if (txd_f) n.smp_cnt = 8'h00;
		else if (st_r.smp_cnt != 8'h00) n.smp_cnt = st_r.smp_cnt - 8'h01;
		// Shorts only report; they touch neither driver nor receiver
		set_f[`CTS_F_LGND]  = short_trip[0];
		set_f[`CTS_F_HBATT] = short_trip[1];
		set_f[`CTS_F_LBATT] = short_trip[2];
		set_f[`CTS_F_HGND]  = short_trip[3];
		set_f[`CTS_F_OC]    = short_trip[2] | short_trip[3];
		// Sticky flags; a set in the clearing cycle wins
		n.flags = (st_r.flags & ~clr_f) | set_f;
		// Low-power entry and exit
		if (low_power_off_state && !st_r.low_power_off_state_d) begin
			n.saved_mode = st_r.mode;
			if (st_r.mode != `CTS_MODE_SLEEP) n.mode = `CTS_MODE_WSLEEP;
		end else if (!low_power_off_state && st_r.low_power_off_state_d) begin
			n.mode = st_r.saved_mode;
		end
		// Software clear first, so a report in the same cycle wins
		if (clr_wake) n.wake = 1'b0;
		// Wake sequencer: three long pulses inside the timeout
		n.wk_len = bus_f ? ((st_r.wk_len != 24'hFFFFFF) ? st_r.wk_len + 1'b1 : st_r.wk_len)
			: 24'h000000;
		case (st_r.wk)
			cts_pkg::WK_IDLE: begin
				// Only a fresh dominant edge starts, so a stuck bus cannot retrigger
				if (low_power_off_state && st_r.mode != `CTS_MODE_SLEEP && dom_start) begin
					n.wk    = cts_pkg::WK_FIRST;
					n.wk_to = st_r.to_sel ? WTO2_CYC : WTO1_CYC;
				end
			end
			cts_pkg::WK_FIRST, cts_pkg::WK_SECOND, cts_pkg::WK_THIRD: begin
				n.wk_to = st_r.wk_to - 1'b1;
				if (!low_power_off_state || st_r.mode == `CTS_MODE_SLEEP || st_r.wk_to == 24'h000001) begin
					n.wk = cts_pkg::WK_IDLE;
				end else if (dom_end && st_r.wk_len > pulse_min) begin
					if (st_r.wk == cts_pkg::WK_THIRD) begin
						n.wk   = cts_pkg::WK_IDLE;
						n.wake = 1'b1;
					end else if (st_r.wk == cts_pkg::WK_FIRST) begin
						n.wk = cts_pkg::WK_SECOND;
					end else begin
						n.wk = cts_pkg::WK_THIRD;
					end
				end
			end
			default: n.wk = cts_pkg::WK_IDLE;
		endcase
		// Pin side follows the next state so outputs match the locks
		drv_nxt   = ~low_power_off_state & (n.mode == `CTS_MODE_NORMAL) & ~n.txd_lock & ~n.rx_lock
			& ~n.ot_lock;
		rxen_nxt  = ~low_power_off_state & n.mode[0] & ~n.rx_lock;
		drive_nxt = drv_nxt & ~txd_f;
		rxd_nxt   = low_power_off_state ? 1'b0 : (rxen_nxt ? ~bus_f : 1'b1);
		irq_nxt   = (|(n.flags & `CTS_ERR_MASK)) & ~n.inhibit;
	end

	// Control and output registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r      <= '0;
			st_r.mode <= `CTS_MODE_RST;
			st_r.txd_d <= 1'b1;
			wr_q_r    <= 1'b0;
			addr_q_r  <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
			rxd       <= 1'b1;
			drv_en    <= 1'b0;
			rx_en     <= 1'b0;
			bus_drive <= 1'b0;
			err_irq   <= 1'b0;
		end else if (hclken) begin
			st_r      <= n;
			wr_q_r    <= wr_q_nxt;
			addr_q_r  <= addr_q_nxt;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= hrdata_nxt;
			rxd       <= rxd_nxt;
			drv_en    <= drv_nxt;
			rx_en     <= rxen_nxt;
			bus_drive <= drive_nxt;
			err_irq   <= irq_nxt;
		end
	end

	// Checks on the supervisor behaviour
	chk_txlow_shut: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(st_r.txd_lock) |-> !drv_en && !st_r.mode[1] && st_r.flags[`CTS_F_TXLOW])
		else $error("transmit stuck low did not shut the drivers");
	chk_rxrec_off: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r.rx_lock |-> !drv_en && !rx_en && !bus_drive)
		else $error("receive lock left driver or receiver on");
	chk_ot_keep_rx: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(st_r.ot_lock) && !st_r.rx_lock && !low_power_off_state && st_r.mode[0] |-> !drv_en && rx_en)
		else $error("overtemperature did not keep the receiver alone");
	chk_ot_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		hclken && st_r.ot_lock && !filt_r[`CTS_I_COOL] |=> st_r.ot_lock)
		else $error("thermal lock released while hot");
	chk_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		err_irq |-> !st_r.inhibit && (st_r.flags & `CTS_ERR_MASK) != 9'h000)
		else $error("interrupt without an uninhibited error");
	chk_listen_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r.mode == `CTS_MODE_LISTEN |-> !drv_en && !bus_drive)
		else $error("listen mode drives the bus");
	chk_wake_seq: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(st_r.wake) |-> $past(st_r.wk) == cts_pkg::WK_THIRD && $past(low_power_off_state))
		else $error("wake reported without the third pulse");
	chk_wake_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r.wk != cts_pkg::WK_IDLE |-> $past(low_power_off_state) && st_r.mode != `CTS_MODE_SLEEP)
		else $error("wake sequencer active outside low-power wake mode");
	chk_low_power_off_state_mode: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(st_r.low_power_off_state_d) && $past(st_r.mode) != `CTS_MODE_SLEEP
		|-> st_r.mode == `CTS_MODE_WSLEEP)
		else $error("low-power entry did not select wake sleep");
	chk_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		hclken && !(wr_q_r && addr_q_r == `CTS_OFF_DIAG) |=> ($past(st_r.flags) & ~st_r.flags)
		== 9'h000)
		else $error("flag dropped without a software clear");
endmodule : cts_supervisor

/* testbench/cts_ctrl_model.sv */
// Protocol controller model that drives the transmit pin
`timescale 1ns/10ps
module cts_ctrl_model (
	input  wire logic       hclk,  // System clock
	input  wire logic       go,    // Start one dominant burst
	input  wire logic [7:0] len,   // Burst length in cycles
	output logic            txd,   // Transmit pin, idles recessive
	output logic            busy   // Burst in progress
);
	logic [7:0] cnt_r;             // Cycles left in the burst
	initial begin
		txd = 1'b1;
		busy = 1'b0;
		cnt_r = 8'h00;
	end
	// Low for len cycles, then back to the pull-up level
	always @(posedge hclk) begin
		if (go && !busy) begin
			txd <= 1'b0;
			busy <= 1'b1;
			cnt_r <= len;
		end else if (busy) begin
			cnt_r <= cnt_r - 8'h01;
			if (cnt_r == 8'h01) begin
				txd <= 1'b1;
				busy <= 1'b0;
			end
		end
	end
endmodule : cts_ctrl_model

/* testbench/cts_supervisor_tb.sv */
// Register-level test bench of the bus supervisor
`timescale 1ns/10ps
module cts_supervisor_tb;
	logic hclk, hresetn, hwrite, txd, go, ll_low;
	logic hclken, hh_high, l_oc, h_oc, hot, cool, lp;
	logic [1:0]  htrans;
	logic [7:0]  haddr;
	logic [31:0] hwdata, hrdata, q;
	logic hreadyout, drv_en, rx_en, bus_drive, err_irq, rxd, busy;
	int failures, cmp_count, cyc;
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	cts_ctrl_model i_ctrl (.hclk(hclk), .go(go), .len(8'h3C), .txd(txd), .busy(busy));
	// Short timeouts keep the run brief
	cts_supervisor #(.TXDOM_NS(1000), .BUSDOM_NS(2000)) i_dut (.hclk(hclk),
		.hresetn(hresetn), .hclken(hclken), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .txd(txd), .rxd_mon(rxd),
		.bus_dominant(bus_drive), .low_line_low(ll_low), .high_line_high(hh_high),
		.low_line_oc(l_oc), .high_line_oc(h_oc), .temp_hot(hot), .temp_cool(cool),
		.low_power_off_state(lp), .rxd(rxd), .drv_en(drv_en), .rx_en(rx_en), .bus_drive(bus_drive),
		.err_irq(err_irq));
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	// Single AHB-Lite word transfer; read data taken at the data-phase edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd
	// One dominant burst from the controller model
	task automatic burst;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		repeat (75) @(posedge hclk);
	endtask : burst
	// Hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			stop_test;
		end
	end
	initial begin
		{hresetn, htrans, hwrite, go, ll_low, hh_high, l_oc, h_oc, hot, lp, haddr, hwdata} <= '0;
		{hclken, cool} <= 2'h3;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
		rd(8'h00, 32'h3);
		rd(8'h04, 32'h0);
		$display("reset test done");
		go <= 1'b1;
		repeat (160) @(posedge hclk);
		go <= 1'b0;
		repeat (70) @(posedge hclk);
		rd(8'h04, 32'h40);
		rd(8'h00, 32'h1);
		chk({err_irq, drv_en, rx_en}, 3'h5);
		ahb(1'b1, 8'h08, 32'h1);
		repeat (3) @(posedge hclk);
		chk(err_irq, 1'b0);
		ahb(1'b1, 8'h00, 32'h3);
		repeat (6) @(posedge hclk);
		chk(drv_en, 1'b1);
		ahb(1'b1, 8'h04, 32'h1FF);
		rd(8'h04, 32'h0);
		ahb(1'b1, 8'h08, 32'h0);
		$display("stuck transmit test done");
		{ll_low, hh_high, l_oc} <= 3'h7;
		repeat (4) burst();
		rd(8'h04, 32'h0);
		burst();
		rd(8'h04, 32'h10D);
		chk({err_irq, drv_en, rx_en}, 3'h3);
		$display("short test done");
		// Hot driver: drivers off, receiver kept, relock until cool and a fall
		hot <= 1'b1;
		cool <= 1'b0;
		repeat (8) @(posedge hclk);
		rd(8'h04, 32'h18D);
		chk({err_irq, drv_en, rx_en}, 3'h5);
		rd(8'h00, 32'h1);
		hot <= 1'b0;
		ahb(1'b1, 8'h00, 32'h3);
		burst();
		chk(drv_en, 1'b0);
		cool <= 1'b1;
		repeat (6) @(posedge hclk);
		burst();
		chk(drv_en, 1'b1);
		$display("overtemp test done");
		// Low-power off: wake sleep forced, mode writes refused, mode restored
		lp <= 1'b1;
		repeat (3) @(posedge hclk);
		rd(8'h00, 32'h2);
		chk(drv_en, 1'b0);
		ahb(1'b1, 8'h00, 32'h0);
		lp <= 1'b0;
		repeat (3) @(posedge hclk);
		rd(8'h00, 32'h3);
		$display("low-power test done");
		stop_test;
	end
endmodule : cts_supervisor_tb
